// File: logic/docs_cal_seq.sv
`timescale 1ns/1ps
// offset calibration sequencer with serial configuration port
module docs_cal_seq
   import docs_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   // reference input, sampled
   input wire logic i_ref_in,
   // serial configuration
   input wire logic i_ser_clk,
   input wire logic i_ser_data,
   input wire logic i_latch_strobe,
   // calibration trigger from controller
   input wire logic i_cal_trig,
   // operating mode
   input wire logic i_rx_mode,
   // comparators, one per channel
   input wire logic i_cmp_inphase_hi,
   input wire logic i_cmp_quad_hi,
   // dac codes
   output logic [docs_pkg::DOCS_DAC_W-1:0] o_offset_current_dac_i,
   output logic [docs_pkg::DOCS_DAC_W-1:0] o_offset_current_dac_q,
   // analog controls
   output logic o_cmp_balance,
   output logic o_agc_off,
   output logic o_out_bias_en,
   output logic o_cal_busy,
   output logic [docs_pkg::DOCS_SLOT_W-1:0] o_slot
);
   // cycle phase
   docs_state_e st_q, st_d;                 // sequencer state
   // configuration state
   logic [DOCS_SHIFT_W-1:0] sh_q, sh_d;     // serial shift register
   logic [DOCS_DIV_W-1:0] div_q, div_d;     // divider setting
   logic bias_q, bias_d;                    // output bias enable
   // pin edge history
   logic sck_q, sck_d;                      // serial clock history
   logic le_q, le_d;                        // strobe history
   logic ref_q, ref_d;                      // reference history
   logic trg_q, trg_d;                      // trigger history
   // divider chain
   logic [DOCS_DIV_W-1:0] cnt_q, cnt_d;     // reference edge count
   logic half_q, half_d;                    // divide by two stage
   // slot tracking
   logic [DOCS_SLOT_W-1:0] slot_q, slot_d;  // active slot number
   logic rx_cal_q, rx_cal_d;                // cycle began in receive
   // combinational strobes
   logic trig_rise;                         // trigger went high
   logic ref_rise;                          // reference went high
   logic slot_tick;                         // one slot period ends
   logic sar_load;                          // preset both channels
   logic sar_step;                          // one search step

   // edge detects on sampled pins
   // history flops reset low, matching the idle pin levels
   assign trig_rise = i_cal_trig & ~trg_q;
   assign ref_rise = i_ref_in & ~ref_q;

   // serial configuration capture
   always_comb begin
      sh_d = sh_q;
      div_d = div_q;
      bias_d = bias_q;
      sck_d = i_ser_clk;
      le_d = i_latch_strobe;
      // shift on serial clock rise, frozen while strobe is high
      if (i_ser_clk && !sck_q && !i_latch_strobe) begin
         sh_d = {sh_q[DOCS_SHIFT_W-2:0], i_ser_data};
      end
      // strobe rise copies an addressed word into the settings
      if (i_latch_strobe && !le_q && (sh_q[1:0] == DOCS_ADDR_CAL)) begin
         div_d = sh_q[DOCS_DIV_LSB +: DOCS_DIV_W];
         bias_d = sh_q[DOCS_BIAS_BIT];
      end
   end

   // register configuration state
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         // divider starts at one, bias off
         sh_q <= '0;
         div_q <= DOCS_DIV_RST;
         bias_q <= 1'b0;
         sck_q <= 1'b0;
         le_q <= 1'b0;
      end else begin
         // take next values
         sh_q <= sh_d;
         div_q <= div_d;
         bias_q <= bias_d;
         sck_q <= sck_d;
         le_q <= le_d;
      end
   end

   // slot clock: reference over divider, then over two
   always_comb begin
      cnt_d = cnt_q;
      half_d = half_q;
      slot_tick = 1'b0;
      ref_d = i_ref_in;
      // trigger realigns the divider so slot one is whole
      if (trig_rise) begin
         cnt_d = '0;
         half_d = 1'b0;
      end else if (ref_rise) begin
         // divider of zero behaves as one
         if (cnt_q + 7'h01 >= ((div_q == '0) ? 7'h01 : div_q)) begin
            // divider wraps: toggle halving stage, tick on its fall
            cnt_d = '0;
            half_d = ~half_q;
            slot_tick = half_q;
         end else begin
            // still counting toward the divider
            cnt_d = cnt_q + 7'h01;
         end
      end
   end

   // register divider chain
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         // counter cleared, halving stage low
         cnt_q <= '0;
         half_q <= 1'b0;
         ref_q <= 1'b0;
      end else begin
         // take next values
         cnt_q <= cnt_d;
         half_q <= half_d;
         ref_q <= ref_d;
      end
   end

   // slot sequencer, mode independent
   always_comb begin
      // defaults: keep state, no channel strobes
      st_d = st_q;
      slot_d = slot_q;
      trg_d = i_cal_trig;
      rx_cal_d = rx_cal_q;
      sar_load = 1'b0;
      sar_step = 1'b0;
      if (trig_rise) begin
         // restart from slot one at any time
         st_d = DOCS_SETTLE;
         slot_d = 5'h01;
         rx_cal_d = i_rx_mode;
         sar_load = 1'b1;
      end else if (slot_tick && (st_q != DOCS_IDLE) && (st_q != DOCS_HOLD)) begin
         // one slot further per tick while a cycle runs
         slot_d = slot_q + 5'h01;
         // a tick that leaves a search slot is one step
         if (st_q == DOCS_SRCH) begin
            sar_step = 1'b1;
         end
         // state follows the slot being entered
         unique case (slot_q + 5'h01)
            DOCS_SLOT_BAL_FIRST: begin
               st_d = DOCS_BAL;
            end
            DOCS_SLOT_BAL_LAST + 5'h01: begin
               st_d = DOCS_SETTLE;          // idle wait slots
            end
            DOCS_SLOT_SRCH_FIRST: begin
               st_d = DOCS_SRCH;
            end
            DOCS_SLOT_HOLD: begin
               st_d = DOCS_HOLD;
            end
            default: begin
               st_d = st_q;                 // other slots keep current state
            end
         endcase
      end
   end

   // register sequencer state
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         // idle, no slot active
         st_q <= DOCS_IDLE;
         slot_q <= '0;
         trg_q <= 1'b0;
         rx_cal_q <= 1'b0;
      end else begin
         // take next values
         st_q <= st_d;
         slot_q <= slot_d;
         trg_q <= trg_d;
         rx_cal_q <= rx_cal_d;
      end
   end

   // independent channels
   // in-phase channel
   docs_sar_chan #(.W(DOCS_DAC_W)) u_chan_i (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_load(sar_load),
      .i_step(sar_step),
      .i_cmp_hi(i_cmp_inphase_hi),
      .o_code(o_offset_current_dac_i)
   );

   // quadrature channel
   docs_sar_chan #(.W(DOCS_DAC_W)) u_chan_q (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_load(sar_load),
      .i_step(sar_step),
      .i_cmp_hi(i_cmp_quad_hi),
      .o_code(o_offset_current_dac_q)
   );

   // outputs
   // state decodes, no extra flops between state and pins
   assign o_cmp_balance = (st_q == DOCS_BAL);
   // busy covers slots one to twenty-one
   assign o_cal_busy = (st_q != DOCS_IDLE) && (st_q != DOCS_HOLD);
   assign o_agc_off = o_cal_busy && rx_cal_q;
   assign o_out_bias_en = bias_q;
   assign o_slot = slot_q;
endmodule

// File: logic/docs_pkg.sv
// How it works
// - slot clock is reference over divider, then two
// - cycle starts only on trigger rising edge
// - slots one to seven only settle circuits
// - slots eight to ten balance comparators
// - slots thirteen to twenty-one run search
// - comparator sign picks polarity, step halves
// - from slot twenty-two hold code
// - eight-bit register drives current dac
// - comparator feeds decision stage updating register
// - each channel has its own comparator
// - agc amplifiers off during receive calibration
// - request accepted in any operating mode
// - config bit enables output common-mode bias
// - divider is seven-bit field, bits 2-8
// - bias enable is bit thirteen of word
// - words shift msb first, latch on strobe
// - two low bits select target register
package docs_pkg;
   localparam int DOCS_SHIFT_W = 20;                 // serial word length
   localparam int DOCS_DIV_W = 7;                    // divider field width
   localparam int DOCS_DAC_W = 8;                    // approximation register width
   localparam int DOCS_SLOT_W = 5;                   // slot counter width
   localparam logic [1:0] DOCS_ADDR_CAL = 2'h3;      // address of offset calibration word
   localparam int DOCS_DIV_LSB = 2;                  // divider field starts above address bits
   localparam int DOCS_BIAS_BIT = 13;                // bias enable position in serial word
   localparam logic [4:0] DOCS_SLOT_SETTLE_END = 5'h07;
   localparam logic [4:0] DOCS_SLOT_BAL_FIRST = 5'h08;
   localparam logic [4:0] DOCS_SLOT_BAL_LAST = 5'h0A;
   localparam logic [4:0] DOCS_SLOT_SRCH_FIRST = 5'h0D;
   localparam logic [4:0] DOCS_SLOT_SRCH_LAST = 5'h15;
   localparam logic [4:0] DOCS_SLOT_HOLD = 5'h16;
   localparam logic [7:0] DOCS_DAC_MID = 8'h80;      // first trial code
   localparam logic [6:0] DOCS_DIV_RST = 7'h01;      // divider reset value
   typedef enum logic [4:0] {
      DOCS_IDLE   = 5'b00001,
      DOCS_SETTLE = 5'b00010,
      DOCS_BAL    = 5'b00100,
      DOCS_SRCH   = 5'b01000,
      DOCS_HOLD   = 5'b10000
   } docs_state_e;
endpackage

// File: logic/docs_sar_chan.sv
`timescale 1ns/1ps
// one channel decision stage and approximation register
module docs_sar_chan
   import docs_pkg::*;
#(
   parameter int W = docs_pkg::DOCS_DAC_W
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   // control
   input wire logic i_load,           // preset first trial
   input wire logic i_step,           // one search slot ends
   input wire logic i_cmp_hi,         // comparator says offset positive
   // result
   output logic [W-1:0] o_code
);
   logic [W-1:0] code_q, code_d;      // current trial code
   logic [W-1:0] bit_q, bit_d;        // bit under trial

   // next trial: keep or drop tested bit, try next lower
   always_comb begin
      code_d = code_q;
      bit_d = bit_q;
      if (i_load) begin
         code_d = W'(DOCS_DAC_MID);
         bit_d = W'(DOCS_DAC_MID);
      end else if (i_step && (bit_q != '0)) begin
         // sign decides polarity, step halves
         if (i_cmp_hi) begin
            code_d = (code_q & ~bit_q) | (bit_q >> 1);
         end else begin
            code_d = code_q | (bit_q >> 1);
         end
         bit_d = bit_q >> 1;
      end
   end

   // register state
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         code_q <= W'(DOCS_DAC_MID);
         bit_q <= '0;
      end else begin
         code_q <= code_d;
         bit_q <= bit_d;
      end
   end

   assign o_code = code_q;
endmodule

// File: test/dc_offset_cal_sequencer_tb.sv
`timescale 1ns/1ps
// bench for the offset calibration sequencer
module dc_offset_cal_sequencer_tb;
   import docs_pkg::*;
   localparam int DIV = 4; // slot is 4*DIV clocks, ref at half rate, cycle about 13 us
   logic i_sys_clk, i_nrst, i_ser_clk, i_ser_data, i_latch_strobe, i_cal_trig;
   logic i_ref_in = 1'b0; // free running reference
   logic i_rx_mode, i_cmp_inphase_hi, i_cmp_quad_hi, o_cmp_balance, o_agc_off, o_out_bias_en, o_cal_busy;
   logic [7:0] o_offset_current_dac_i, o_offset_current_dac_q;
   logic [4:0] o_slot;
   int num_errors = 0;
   int comparisons = 0;
   int cyc = 0;
   docs_ctl_model ctl (.i_sys_clk, .o_ser_clk(i_ser_clk), .o_ser_data(i_ser_data),
      .o_latch_strobe(i_latch_strobe), .o_cal_trig(i_cal_trig));
   docs_cal_seq dut (.i_sys_clk, .i_nrst, .i_ref_in, .i_ser_clk, .i_ser_data, .i_latch_strobe, .i_cal_trig,
      .i_rx_mode, .i_cmp_inphase_hi, .i_cmp_quad_hi, .o_offset_current_dac_i, .o_offset_current_dac_q,
      .o_cmp_balance, .o_agc_off, .o_out_bias_en, .o_cal_busy, .o_slot);
   initial begin
      i_sys_clk = 1'b0;
      forever #20 i_sys_clk = ~i_sys_clk;
   end
   // reference toggles, hang guard counts
   always @(posedge i_sys_clk) begin
      i_ref_in <= ~i_ref_in;
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         num_errors++;
         close_out();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("comparisons=%0d mismatches=%0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wait_slot(input logic [4:0] s);
      for (int k = 0; k < 3000 && o_slot !== s; k++) @(negedge i_sys_clk);
   endtask
   // bias and divider loaded, other address ignored
   task automatic t_config();
      chk(o_offset_current_dac_i, 8'h80);
      ctl.send_word(20'h02003 | (20'(DIV) << DOCS_DIV_LSB));
      ctl.send_word(20'h00002);
      repeat (4) @(negedge i_sys_clk);
      chk({7'h00, o_out_bias_en}, 8'h01);
      $display("test config done");
   endtask
   // rx cycle: slot length, agc, channels apart
   task automatic t_cal();
      int n;
      n = 0;
      @(posedge i_sys_clk);
      i_rx_mode <= 1'b1;
      i_cmp_inphase_hi <= 1'b1;
      ctl.trig_edge();
      wait_slot(5'h02);
      while (o_slot === 5'h02 && n < 99) begin
         @(negedge i_sys_clk);
         n++;
      end
      chk(8'(n), 8'(4 * DIV));
      chk({7'h00, o_agc_off}, 8'h01);
      wait_slot(5'h09);
      chk({7'h00, o_cmp_balance}, 8'h01);
      wait_slot(5'h0C);
      chk({7'h00, o_cmp_balance}, 8'h00);
      chk({7'h00, o_cal_busy}, 8'h01);
      wait_slot(5'h16);
      chk({7'h00, o_cal_busy}, 8'h00);
      chk(o_offset_current_dac_i, 8'h00);
      chk(o_offset_current_dac_q, 8'hFF);
      repeat (40) @(negedge i_sys_clk);
      chk(o_offset_current_dac_q, 8'hFF);
      $display("test cal done");
   endtask
   // tx mode, restart while settling
   task automatic t_restart();
      @(posedge i_sys_clk);
      i_rx_mode <= 1'b0;
      i_cmp_inphase_hi <= 1'b0;
      i_cmp_quad_hi <= 1'b1;
      ctl.trig_edge();
      wait_slot(5'h05);
      chk({7'h00, o_agc_off}, 8'h00);
      chk(o_offset_current_dac_i, 8'h80);
      ctl.trig_edge();
      repeat (3) @(negedge i_sys_clk);
      chk({3'h0, o_slot}, 8'h01);
      wait_slot(5'h16);
      chk(o_offset_current_dac_i, 8'hFF);
      chk(o_offset_current_dac_q, 8'h00);
      $display("test restart done");
   endtask
   initial begin
      i_nrst = 1'b0;
      i_rx_mode = 1'b0;
      i_cmp_inphase_hi = 1'b0;
      i_cmp_quad_hi = 1'b0;
      repeat (20) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      @(negedge i_sys_clk);
      t_config();
      t_cal();
      t_restart();
      close_out();
   end
endmodule

// File: test/docs_cal_seq_sva.sv
`timescale 1ns/1ps
// timing checks on sequencer outputs
module docs_cal_seq_sva (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   // watched signals
   input wire logic i_cal_trig,
   input wire logic o_cal_busy,
   input wire logic o_cmp_balance,
   input wire logic o_agc_off,
   input wire logic [4:0] o_slot,
   input wire logic [7:0] o_offset_current_dac_i,
   input wire logic [7:0] o_offset_current_dac_q
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   // trigger edge, then first slot
   sequence trig_rise; $rose(i_cal_trig); endsequence
   sequence slot_one; o_slot == 5'h01 && o_cal_busy; endsequence
   start_slot_a: assert property (trig_rise |-> ##[1:2] slot_one) else $error("no start");
   balance_slot_a: assert property (o_cmp_balance == (o_slot >= 5'h08 && o_slot <= 5'h0A))
      else $error("balance");
   busy_slot_a: assert property (o_cal_busy == (o_slot >= 5'h01 && o_slot <= 5'h15)) else $error("busy");
   slot_step_a: assert property ($changed(o_slot) |-> o_slot == $past(o_slot) + 5'h01 || o_slot == 5'h01)
      else $error("step");
   settle_mid_a: assert property (o_cal_busy && o_slot <= 5'h0C |-> o_offset_current_dac_i == 8'h80
      && o_offset_current_dac_q == 8'h80) else $error("preset");
   hold_code_a: assert property (o_slot == 5'h16 && $past(o_slot) == 5'h16 |-> $stable(o_offset_current_dac_i)
      && $stable(o_offset_current_dac_q)) else $error("hold");
   code_when_a: assert property ($changed(o_offset_current_dac_q) |-> o_slot >= 5'h0E || o_slot == 5'h01)
      else $error("code");
   agc_busy_a: assert property (o_agc_off |-> o_cal_busy) else $error("agc");
endmodule
bind docs_cal_seq docs_cal_seq_sva u_sva (.i_sys_clk, .i_nrst, .i_cal_trig, .o_cal_busy, .o_cmp_balance,
   .o_agc_off, .o_slot, .o_offset_current_dac_i, .o_offset_current_dac_q);

// File: test/docs_ctl_model.sv
`timescale 1ns/1ps
// controller side: serial loader and trigger
module docs_ctl_model (
   input wire logic i_sys_clk,
   output logic o_ser_clk,
   output logic o_ser_data,
   output logic o_latch_strobe,
   output logic o_cal_trig
);
   // idle levels
   initial begin
      o_ser_clk = 1'b0;
      o_ser_data = 1'b0;
      o_latch_strobe = 1'b0;
      o_cal_trig = 1'b0;
   end
   // shift msb first, then latch
   task automatic send_word(input logic [19:0] w);
      for (int i = 19; i >= 0; i--) begin
         @(posedge i_sys_clk) o_ser_data <= w[i];
         @(posedge i_sys_clk) o_ser_clk <= 1'b1;
         @(posedge i_sys_clk) o_ser_clk <= 1'b0;
      end
      @(posedge i_sys_clk) o_latch_strobe <= 1'b1;
      @(posedge i_sys_clk) o_latch_strobe <= 1'b0;
      o_ser_data <= ~w[0]; // released line shows inverse
   endtask
   // low gap, then edge held high
   task automatic trig_edge();
      @(posedge i_sys_clk) o_cal_trig <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
      o_cal_trig <= 1'b1;
   endtask
endmodule
